/* rtl/clw_pkg.sv */
// Package: register map, field positions and carrier types of the lock-aware victim selector
package clw_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] LOCK_CTRL_ADDR = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  // ==========================================================
  // Lock control fields
  localparam int W3_TARGET_BIT = 9;
  localparam int W3_HOLD_BIT = 8;
  localparam int W2_TARGET_BIT = 1;
  localparam int W2_HOLD_BIT = 0;
  localparam int LOCK_MODE_BIT = 12;
  // Status fields
  localparam int ST_LOCKED_BIT = 0;
  localparam int ST_MODE_BIT = 1;
  localparam int ST_WAY_LO = 2;
  localparam int ST_FILL_BIT = 4;
  // ==========================================================
  // Sizes and reset values
  localparam int LRU_W = 6;
  localparam int INDEX_W = 8;
  localparam logic [5:0] LRU_RESET = 6'h00;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  // ==========================================================
  // Carriers
  typedef logic [1:0] clw_way_t;

  typedef struct packed {
    logic w3_target;
    logic w3_hold;
    logic w2_target;
    logic w2_hold;
  } clw_lock_ctl_t;

  typedef struct packed {
    logic valid;
    logic prefetch;
    logic hit;
    logic [7:0] index;
  } clw_miss_req_t;

  typedef struct packed {
    logic we;
    logic [7:0] index;
    logic [5:0] lru;
  } clw_lru_wr_t;

  localparam clw_lock_ctl_t LOCK_CTL_RESET = '{default: 1'b0};
endpackage : clw_pkg

/* rtl/clw_way_select.sv */
// Victim-way selector with way 2/3 locking, LRU store and APB register slave
//
// What this block does
// [R1] Status word bit 12 enters locking mode
// [R2] Lock settings act only in locking mode; the locked status bit follows the hold bits in either mode
// [R3] Prefetch miss fills way chosen by lock bits
// [R4] Prefetch hit loads nothing, keeps entries
// [R5] Other misses use only the hold bits
// [R6] Reserved control bits read zero
// [R7] Way 3 forced load places line there
// [R8] Way 2 forced load places line there
// [R9] Otherwise victim from LRU held-way mapping
// [R10] Software never sets both target bits
// [R11] Any hold bit means cache locked
// [R12] Held way never overwritten except forced load
// [R13] Way 2 held: LRU to ways 3/1/0
// [R14] Way 3 held: LRU to ways 2/1/0
// [R15] Both held: top LRU bit picks 1/0
// [R16] Held mappings replace base in locking mode
// [R17] Software changes control from uncached code
// [R18] Base LRU mapping to ways 3/2/1/0
// [R19] LRU bits clear on power-on reset
// [R20] Victim computed in cycle of miss
// [R21] Lock bits write-only, read zero, reset clear
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
module clw_way_select #(
  parameter int ENTRIES = 256
) (
  // Clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core side
  input wire logic [31:0] status_word,
  input wire clw_pkg::clw_miss_req_t miss_req,
  input wire clw_pkg::clw_lru_wr_t lru_wr,
  // Victim answer
  output logic fill_valid,
  output clw_pkg::clw_way_t fill_way,
  output logic [5:0] entry_lru
);

  // Index width fixes the store depth; any other depth would alias entries
  if (ENTRIES != (1 << clw_pkg::INDEX_W)) begin : g_bad_entries
    $error("ENTRIES must match the index width");
  end

  // ==========================================================
  // Mapping functions
  function automatic clw_pkg::clw_way_t base_way(input logic [5:0] l);
    clw_pkg::clw_way_t w;
    w = 2'h0;
    case (l)
      6'h00, 6'h04, 6'h14, 6'h20, 6'h30, 6'h34: w = 2'h3;
      6'h01, 6'h03, 6'h0b, 6'h21, 6'h29, 6'h2b: w = 2'h2;
      6'h06, 6'h07, 6'h0f, 6'h16, 6'h1e, 6'h1f: w = 2'h1;
      default: w = 2'h0;
    endcase
    return w;
  endfunction : base_way

  function automatic clw_pkg::clw_way_t held_way(input logic [5:0] l, input logic h2,
                                                 input logic h3);
    clw_pkg::clw_way_t w;
    w = 2'h0;
    if (h2 && h3) begin
      w = l[5] ? 2'h0 : 2'h1; // [R15]
    end else if (h2) begin
      case (l) // [R13]
        6'h00, 6'h01, 6'h04, 6'h14, 6'h20, 6'h21, 6'h30, 6'h34: w = 2'h3;
        6'h03, 6'h06, 6'h07, 6'h0b, 6'h0f, 6'h16, 6'h1e, 6'h1f: w = 2'h1;
        default: w = 2'h0;
      endcase
    end else if (h3) begin
      case (l) // [R14]
        6'h00, 6'h01, 6'h03, 6'h0b, 6'h20, 6'h21, 6'h29, 6'h2b: w = 2'h2;
        6'h04, 6'h06, 6'h07, 6'h0f, 6'h14, 6'h16, 6'h1e, 6'h1f: w = 2'h1;
        default: w = 2'h0;
      endcase
    end else begin
      w = base_way(l); // [R16] [R18]
    end
    return w;
  endfunction : held_way

  // ==========================================================
  // LRU store, one six-bit word per entry
  logic [5:0] lru_mem_q [ENTRIES];

  // Whole array on the async reset costs flops but gives a clean power-on state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ENTRIES; i++) begin
        lru_mem_q[i] <= clw_pkg::LRU_RESET; // [R19]
      end
    end else if (lru_wr.we) begin
      lru_mem_q[lru_wr.index] <= lru_wr.lru;
    end
  end

  // ==========================================================
  // Lock control and victim decode
  clw_pkg::clw_lock_ctl_t ctl_q, ctl_d;
  wire logic lock_mode = status_word[clw_pkg::LOCK_MODE_BIT]; // [R1]
  wire logic [5:0] lru_rd = lru_mem_q[miss_req.index];
  wire logic hold2 = lock_mode & ctl_q.w2_hold; // [R2]
  wire logic hold3 = lock_mode & ctl_q.w3_hold; // [R2]
  wire logic locked = ctl_q.w2_hold | ctl_q.w3_hold; // [R11]
  wire logic is_prefetch_instruction = miss_req.prefetch;
  // Forced loads apply to prefetch only; other misses see the hold bits alone
  wire logic force3 = is_prefetch_instruction & hold3 & ctl_q.w3_target & ~ctl_q.w2_target; // [R7] [R5]
  wire logic force2 = is_prefetch_instruction & hold2 & ctl_q.w2_target & ~ctl_q.w3_target; // [R8] [R5]
  wire clw_pkg::clw_way_t lru_way = held_way(lru_rd, hold2, hold3); // [R9] [R12]
  wire clw_pkg::clw_way_t victim_way = force3 ? 2'h3 : (force2 ? 2'h2 : lru_way); // [R3]
  // A hit, prefetch or not, never asks for a fill
  wire logic miss_now = miss_req.valid & ~miss_req.hit; // [R4] [R20]

  logic fill_valid_q;
  clw_pkg::clw_way_t fill_way_q;
  logic [5:0] entry_lru_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_valid_q <= 1'b0;
      fill_way_q <= 2'h0;
      entry_lru_q <= clw_pkg::LRU_RESET;
    end else begin
      fill_valid_q <= miss_now; // [R20]
      fill_way_q <= miss_now ? victim_way : fill_way_q;
      entry_lru_q <= lru_rd;
    end
  end

  // ==========================================================
  // APB slave: answer in the first access cycle, no wait states
  wire logic setup = psel & ~penable;
  wire logic hit_ctl = (paddr == clw_pkg::LOCK_CTRL_ADDR);
  wire logic hit_st = (paddr == clw_pkg::STATUS_ADDR);
  wire logic wr_ctl = psel & penable & pready & pwrite & hit_ctl;
  logic [31:0] rd_d;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;

  always_comb begin
    ctl_d = ctl_q;
    if (wr_ctl) begin
      ctl_d.w3_target = pwdata[clw_pkg::W3_TARGET_BIT];
      ctl_d.w3_hold = pwdata[clw_pkg::W3_HOLD_BIT];
      ctl_d.w2_target = pwdata[clw_pkg::W2_TARGET_BIT];
      ctl_d.w2_hold = pwdata[clw_pkg::W2_HOLD_BIT];
    end
  end

  always_comb begin
    rd_d = clw_pkg::RDATA_ZERO; // [R6] [R21]
    if (hit_st && !pwrite) begin
      rd_d[clw_pkg::ST_LOCKED_BIT] = locked;
      rd_d[clw_pkg::ST_MODE_BIT] = lock_mode;
      rd_d[clw_pkg::ST_WAY_LO +: 2] = fill_way_q;
      rd_d[clw_pkg::ST_FILL_BIT] = fill_valid_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= clw_pkg::LOCK_CTL_RESET; // [R21]
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= clw_pkg::RDATA_ZERO;
    end else begin
      ctl_q <= ctl_d;
      pready_q <= setup;
      pslverr_q <= setup & ~(hit_ctl | hit_st);
      prdata_q <= setup ? rd_d : clw_pkg::RDATA_ZERO;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign fill_valid = fill_valid_q;
  assign fill_way = fill_way_q;
  assign entry_lru = entry_lru_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  force_way3_a: assert property ( // [R7]
    miss_now && lock_mode && is_prefetch_instruction && ctl_q.w3_hold && ctl_q.w3_target && !ctl_q.w2_target
    |=> fill_valid && fill_way == 2'h3)
    else $error("forced way 3 load missed");

  force_way2_a: assert property ( // [R8]
    miss_now && lock_mode && is_prefetch_instruction && ctl_q.w2_hold && ctl_q.w2_target && !ctl_q.w3_target
    |=> fill_valid && fill_way == 2'h2)
    else $error("forced way 2 load missed");

  prefetch_instruction_hit_a: assert property ( // [R4]
    miss_req.valid && miss_req.hit |=> !fill_valid)
    else $error("fill requested on hit");

  unlocked_base_a: assert property ( // [R2]
    miss_now && !lock_mode |=> fill_way == base_way(entry_lru))
    else $error("lock bits used outside locking mode");

  hold2_protect_a: assert property ( // [R12]
    miss_now && hold2 && !force2 |=> fill_way != 2'h2)
    else $error("held way 2 chosen");

  hold3_protect_a: assert property ( // [R12]
    miss_now && hold3 && !force3 |=> fill_way != 2'h3)
    else $error("held way 3 chosen");

  both_held_a: assert property ( // [R15]
    miss_now && hold2 && hold3 && !is_prefetch_instruction |=> fill_way == (entry_lru[5] ? 2'h0 : 2'h1))
    else $error("both-held mapping wrong");

  ctl_read_zero_a: assert property ( // [R21]
    psel && penable && pready && !pwrite && hit_ctl |-> prdata == 32'h0000_0000)
    else $error("control register read not zero");

  apb_answer_a: assert property (
    psel && !penable ##1 psel && penable |-> pready)
    else $error("access phase not answered");

  locked_status_a: assert property ( // [R11]
    setup && hit_st && !pwrite && locked ##1 psel && penable |-> prdata[0])
    else $error("locked status not shown");

  // Spot checks written from the tables, not from the mapping functions
  base_way3_a: assert property ( // [R18]
    miss_now && !lock_mode && lru_rd inside {6'h00, 6'h04, 6'h14, 6'h20, 6'h30, 6'h34}
    |=> fill_way == 2'h3)
    else $error("base mapping to way 3 wrong");

  base_way0_a: assert property ( // [R18]
    miss_now && !lock_mode && lru_rd[5:3] == 3'h7 |=> fill_way == 2'h0)
    else $error("base mapping to way 0 wrong");

  hold2_map_a: assert property ( // [R13]
    miss_now && hold2 && !hold3 && !force2 && lru_rd inside {6'h00, 6'h01, 6'h04, 6'h14}
    |=> fill_way == 2'h3)
    else $error("way 2 held mapping to way 3 wrong");

  hold2_way1_a: assert property ( // [R13]
    miss_now && hold2 && !hold3 && !force2 && lru_rd inside {6'h03, 6'h0b}
    |=> fill_way == 2'h1)
    else $error("way 2 held mapping to way 1 wrong");

  hold3_map_a: assert property ( // [R14]
    miss_now && hold3 && !hold2 && !force3 && lru_rd inside {6'h00, 6'h01, 6'h03, 6'h0b}
    |=> fill_way == 2'h2)
    else $error("way 3 held mapping to way 2 wrong");

  hold3_way1_a: assert property ( // [R14]
    miss_now && hold3 && !hold2 && !force3 && lru_rd inside {6'h04, 6'h14}
    |=> fill_way == 2'h1)
    else $error("way 3 held mapping to way 1 wrong");

  nopref_hold_a: assert property ( // [R5]
    miss_now && !is_prefetch_instruction && hold3 && !hold2 && ctl_q.w3_target && lru_rd == 6'h00
    |=> fill_way == 2'h2)
    else $error("target bit used on a non-prefetch miss");

  no_hold_base_a: assert property ( // [R16]
    miss_now && lock_mode && !ctl_q.w2_hold && !ctl_q.w3_hold && lru_rd == 6'h01
    |=> fill_way == 2'h2)
    else $error("base mapping not used without holds");

  fill_pulse_a: assert property ( // [R20]
    miss_now |=> fill_valid && entry_lru == $past(lru_rd))
    else $error("miss not answered in the next cycle");

  idle_no_fill_a: assert property ( // [R20]
    !miss_req.valid |=> !fill_valid)
    else $error("fill without a lookup");

  way_holds_a: assert property ( // [R20]
    !miss_now |=> $stable(fill_way))
    else $error("victim way changed without a miss");

  ctl_reserved_a: assert property ( // [R6]
    psel && penable && pready && !pwrite |-> prdata[31:5] == 27'h0)
    else $error("reserved read bits not zero");

  ctl_write_a: assert property ( // [R11]
    wr_ctl |=> ctl_q.w3_hold == $past(pwdata[clw_pkg::W3_HOLD_BIT])
      && ctl_q.w2_hold == $past(pwdata[clw_pkg::W2_HOLD_BIT]))
    else $error("hold bits not written");

  bad_addr_a: assert property (
    setup && !hit_ctl && !hit_st |=> pready && pslverr)
    else $error("unmapped access not refused");

  mode_status_a: assert property ( // [R1]
    setup && hit_st && !pwrite ##1 psel && penable
    |-> prdata[clw_pkg::ST_MODE_BIT] == $past(lock_mode))
    else $error("lock mode status not shown");

  cover_force3_c: cover property (miss_now && force3 ##1 fill_way == 2'h3);
  cover_force2_c: cover property (miss_now && force2 ##1 fill_way == 2'h2);
  cover_both_c: cover property (miss_now && hold2 && hold3);
  cover_wr_c: cover property (wr_ctl);
  cover_nopref_c: cover property (miss_now && !is_prefetch_instruction && hold3 && ctl_q.w3_target);

endmodule : clw_way_select

/* verif/clw_core_model.sv */
// Core-side model: status word, cache lookups and LRU writes
`timescale 1ns/1ps
module clw_core_model (
  // Clock
  input wire logic pclk,
  // Core outputs
  output logic [31:0] status_word,
  output clw_pkg::clw_miss_req_t miss_req,
  output clw_pkg::clw_lru_wr_t lru_wr
);
  initial begin
    status_word = 32'h0000_0000;
    miss_req = '0;
    lru_wr = '0;
  end
  // Idle fields inverted so a stale value is never mistaken for a request
  task automatic lookup(input logic [7:0] idx, input logic pf, input logic hit);
    @(posedge pclk);
    miss_req <= '{valid: 1'b1, prefetch: pf, hit: hit, index: idx};
    @(posedge pclk);
    miss_req <= '{valid: 1'b0, prefetch: ~pf, hit: ~hit, index: ~idx};
  endtask : lookup
  task automatic set_lru(input logic [7:0] idx, input logic [5:0] v);
    @(posedge pclk);
    lru_wr <= '{we: 1'b1, index: idx, lru: v};
    @(posedge pclk);
    lru_wr <= '{we: 1'b0, index: ~idx, lru: ~v};
  endtask : set_lru
  // Other status bits inverted to show only bit 12 matters
  task automatic set_mode(input logic m);
    @(posedge pclk);
    status_word <= m ? 32'h0000_1000 : 32'hffff_efff;
  endtask : set_mode
endmodule : clw_core_model

/* verif/cache_lock_way_select_tb.sv */
// Testbench: APB register checks and victim-way selection sweep
`timescale 1ns/1ps
module cache_lock_way_select_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fill_valid, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, status_word;
  clw_pkg::clw_miss_req_t miss_req;
  clw_pkg::clw_lru_wr_t lru_wr;
  clw_pkg::clw_way_t fill_way;
  logic [5:0] entry_lru;
  logic [1:0] ew;
  int errors = 0;
  int samples_checked = 0;
  logic [5:0] pats [24] = '{6'h00, 6'h04, 6'h14, 6'h20, 6'h30, 6'h34, 6'h01, 6'h03,
    6'h0b, 6'h21, 6'h29, 6'h2b, 6'h06, 6'h07, 6'h0f, 6'h16, 6'h1e, 6'h1f, 6'h38,
    6'h39, 6'h3b, 6'h3c, 6'h3e, 6'h3f};
  // Lock settings as {t3, h3, t2, h2}
  // Targets without their hold (6, 9) must not force; both targets never set together
  logic [3:0] ctls [10] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'hc, 4'hd, 4'h3, 4'h7, 4'h6, 4'h9};

  clw_way_select DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .status_word, .miss_req, .lru_wr, .fill_valid,
    .fill_way, .entry_lru);
  clw_core_model core (.pclk, .status_word, .miss_req, .lru_wr);

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("pready_wait", 32'h1, n);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [1:0] exp_way(input logic [5:0] l, input logic md,
                                         input logic pf, input logic [3:0] c);
    if (md & pf & c[3] & c[2] & !c[1]) return 2'h3;
    if (md & pf & c[1] & c[0] & !c[3]) return 2'h2;
    if (md & c[2] & c[0]) return l[5] ? 2'h0 : 2'h1;
    if (md & c[0]) case (l)
      6'h00, 6'h01, 6'h04, 6'h14, 6'h20, 6'h21, 6'h30, 6'h34: return 2'h3;
      6'h03, 6'h06, 6'h07, 6'h0b, 6'h0f, 6'h16, 6'h1e, 6'h1f: return 2'h1;
      default: return 2'h0;
    endcase
    if (md & c[2]) case (l)
      6'h00, 6'h01, 6'h03, 6'h0b, 6'h20, 6'h21, 6'h29, 6'h2b: return 2'h2;
      6'h04, 6'h06, 6'h07, 6'h0f, 6'h14, 6'h16, 6'h1e, 6'h1f: return 2'h1;
      default: return 2'h0;
    endcase
    if (l inside {6'h00, 6'h04, 6'h14, 6'h20, 6'h30, 6'h34}) return 2'h3;
    if (l inside {6'h01, 6'h03, 6'h0b, 6'h21, 6'h29, 6'h2b}) return 2'h2;
    return (l inside {6'h06, 6'h07, 6'h0f, 6'h16, 6'h1e, 6'h1f}) ? 2'h1 : 2'h0;
  endfunction : exp_way
  task automatic tally_and_finish;
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Clock, watchdog and tests
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    #1_000_000;
    errors++;
    tally_and_finish();
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    core.lookup(8'h05, 1'b0, 1'b0);
    #1 chk("entry_lru", 32'h0, {26'h0, entry_lru});
    chk("fill_way", 32'h3, {30'h0, fill_way});
    apb(1'b1, 12'h008, 32'h0000_0003);
    chk("pslverr", 32'h1, {31'h0, err});
    for (int i = 0; i < 24; i++) core.set_lru({2'h0, pats[i]}, pats[i]);
    foreach (ctls[k]) begin
      apb(1'b1, 12'h000, {22'h0, ctls[k][3:2], 6'h0, ctls[k][1:0]});
      apb(1'b0, 12'h000, 32'h0);
      chk("lock_ctrl", 32'h0, rd);
      for (int md = 0; md < 2; md++) begin
        core.set_mode(md[0]);
        apb(1'b0, 12'h004, 32'h0);
        chk("status", {md[0], ctls[k][2] | ctls[k][0]}, rd & 32'h3);
        for (int i = 0; i < 48; i++) begin
          ew = exp_way(pats[i/2], md[0], i[0], ctls[k]);
          core.lookup({2'h0, pats[i/2]}, i[0], 1'b0);
          #1 chk("fill_way", ew, fill_way);
          chk("fill_valid", 32'h1, {31'h0, fill_valid});
          chk("entry_lru", pats[i/2], entry_lru);
          core.lookup({2'h0, pats[i/2]}, i[0], 1'b1);
          #1 chk("hit_fill", 32'h0, {31'h0, fill_valid});
        end
      end
    end
    tally_and_finish();
  end
endmodule : cache_lock_way_select_tb
